// file: instrument_digital_io_port.sv
// Seven-pin digital I/O port with Wishbone registers
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module instrument_digital_io_port
  import dio_port_pkg::*;
#(
  parameter int PWM_W = 24
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire wb_req_type       wb_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  // Port pins
  input  wire logic [NPIN-1:0]  pin_i,
  output logic [NPIN-1:0]       pin_o,
  output logic [NPIN-1:0]       pin_oe_o,
  // Instrument side
  input  wire logic             prot_trip_i,
  output logic                  supply_en_o,
  output logic                  protection_state_level_o,
  output logic                  trig_o,
  output logic                  irq_o
);

  generate
    if (PWM_W < 18 || PWM_W > 32) begin : g_bad_w
      $error("PWM_W must lie between 18 and 32");
    end
  endgenerate

  localparam logic [PWM_W-1:0] PER_RST = PWM_W'(PWM_PER_CYC);
  localparam logic [PWM_W-1:0] LOW_RST = PWM_W'(PWM_LOW_CYC);

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic pin_mode_type mode_of(input logic [13:0] m,
                                           input int          k);
    return pin_mode_type'(m[2*k +: 2]);
  endfunction : mode_of

  logic [13:0]      mode_q;
  logic [6:0]       inv_q;
  logic [6:0]       oval_q;
  logic [PWM_W-1:0] per_q;
  logic [PWM_W-1:0] low_q;
  logic [PWM_W-1:0] cnt_q;
  logic [6:0]       s1_q;
  logic [6:0]       s2_q;
  logic [6:0]       s3_q;
  logic [6:0]       lvl_q;
  logic [6:0]       stat_q;
  logic [6:0]       mask_q;
  logic             on_q;
  logic             prot_q;
  logic             ack_q;
  logic [31:0]      dat_q;
  logic             irq_q;
  logic [6:0]       pin_q;
  logic [6:0]       oe_q;
  logic             trig_q;
  logic             en_q;

  // Bus decode
  wire        req_w  = wb_i.cyc & wb_i.stb & ~ack_q;
  wire        wr_w   = req_w & wb_i.we;
  wire        rd_w   = req_w & ~wb_i.we;
  wire [7:0]  a_w    = wb_i.adr;
  wire        w_mode = wr_w && a_w == ADR_MODE;
  wire        w_inv  = wr_w && a_w == ADR_INV;
  wire        w_oval = wr_w && a_w == ADR_OVAL;
  wire        w_per  = wr_w && a_w == ADR_PPER;
  wire        w_low  = wr_w && a_w == ADR_PLOW;
  wire        w_mask = wr_w && a_w == ADR_MASK;
  wire        w_sup  = wr_w && a_w == ADR_SUP;
  wire        r_stat = rd_w && a_w == ADR_STAT;
  wire [31:0] wm_mode = merge({18'h0, mode_q}, wb_i.dat, wb_i.sel);
  wire [31:0] wm_inv  = merge({25'h0, inv_q}, wb_i.dat, wb_i.sel);
  wire [31:0] wm_oval = merge({25'h0, oval_q}, wb_i.dat, wb_i.sel);
  wire [31:0] wm_per  = merge(32'(per_q), wb_i.dat, wb_i.sel);
  wire [31:0] wm_low  = merge(32'(low_q), wb_i.dat, wb_i.sel);
  wire [31:0] wm_mask = merge({25'h0, mask_q}, wb_i.dat, wb_i.sel);
  wire        sw_on   = w_sup & wb_i.sel[0] & wb_i.dat[SUP_ON];
  wire        sw_off  = w_sup & wb_i.sel[0] & ~wb_i.dat[SUP_ON];

  // Pin sampling: a level is taken only once two stages agree
  wire [6:0] lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  wire [6:0] ef_q  = lvl_q ^ inv_q;
  wire [6:0] ef_d  = lvl_d ^ inv_q;
  wire [6:0] fall_w = ef_q & ~ef_d;

  wire [6:0] dflt_w;
  wire [6:0] inp_w;
  genvar gk;
  generate
    for (gk = 0; gk < NPIN; gk++) begin : g_mode
      assign dflt_w[gk] = mode_of(mode_q, gk) == MODE_DEFAULT;
      assign inp_w[gk]  = mode_of(mode_q, gk) == MODE_INPUT;
    end
  endgenerate

  wire clr_ev = fall_w[PIN_CLR] & dflt_w[PIN_CLR];
  wire trg_ev = fall_w[PIN_TRIG] & dflt_w[PIN_TRIG];
  wire inh_w  = ef_q[PIN_INH] & dflt_w[PIN_INH];
  wire son_ev = fall_w[PIN_SON] & dflt_w[PIN_SON];
  wire soff_ev = fall_w[PIN_SOFF] & dflt_w[PIN_SOFF];

  // A new trip wins over a clearing pulse in the same cycle
  wire prot_d = prot_trip_i | (prot_q & ~clr_ev);
  wire on_d = (soff_ev | inh_w | prot_d) ? 1'b0 :
              (son_ev | sw_on)           ? 1'b1 :
              sw_off                     ? 1'b0 : on_q;

  // Shared waveform counter; low share comes first in each period
  wire [PWM_W-1:0] cnt_d = (cnt_q >= per_q - 1'b1) ?
                           '0 : cnt_q + 1'b1;
  wire pwm_w = cnt_q >= low_q;

  wire [6:0] drv_w;
  wire [6:0] den_w;
  generate
    for (gk = 0; gk < NPIN; gk++) begin : g_drv
      wire pin_mode_type m = mode_of(mode_q, gk);
      wire dval = (gk == PIN_PROT)  ? ~prot_d :
                  (gk == PIN_OFFST) ? on_d : 1'b1;
      assign drv_w[gk] =
        (m == MODE_STATIC) ? ~oval_q[gk] ^ inv_q[gk] :
        (m == MODE_PWM)    ? pwm_w ^ inv_q[gk] :
        dval ^ inv_q[gk];
      assign den_w[gk] = (m == MODE_STATIC) || (m == MODE_PWM) ||
                         (m == MODE_DEFAULT &&
                          (gk == PIN_PROT || gk == PIN_OFFST));
    end
  endgenerate

  // Falling edges seen on pins not being driven are events
  wire [6:0] ev_w   = fall_w & ~oe_q;
  wire [6:0] stat_d = (r_stat ? 7'h00 : stat_q) | ev_w;
  wire [6:0] mask_d = w_mask ? wm_mask[6:0] : mask_q;

  wire [31:0] rdat_w =
    (a_w == ADR_MODE) ? {18'h0, mode_q} :
    (a_w == ADR_INV)  ? {25'h0, inv_q} :
    (a_w == ADR_OVAL) ? {25'h0, oval_q} :
    (a_w == ADR_PPER) ? 32'(per_q) :
    (a_w == ADR_PLOW) ? 32'(low_q) :
    (a_w == ADR_PIN)  ? {25'h0, ef_q} :
    (a_w == ADR_STAT) ? {25'h0, stat_q} :
    (a_w == ADR_MASK) ? {25'h0, mask_q} :
    (a_w == ADR_SUP)  ? {29'h0, en_q, prot_q, on_q} : 32'h0;

  always_ff @(posedge clk_i) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_RST;
      inv_q  <= INV_RST;
      oval_q <= OVAL_RST;
      per_q  <= PER_RST;
      low_q  <= LOW_RST;
      mask_q <= 7'h00;
    end else begin
      if (w_mode) mode_q <= wm_mode[13:0];
      if (w_inv) inv_q <= wm_inv[6:0];
      if (w_oval) oval_q <= wm_oval[6:0];
      if (w_per) per_q <= wm_per[PWM_W-1:0];
      if (w_low) low_q <= wm_low[PWM_W-1:0];
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q  <= LVL_RST;
      stat_q <= 7'h00;
      on_q   <= 1'b0;
      prot_q <= 1'b0;
      cnt_q  <= '0;
      irq_q  <= 1'b0;
      trig_q <= 1'b0;
      en_q   <= 1'b0;
    end else begin
      lvl_q  <= lvl_d;
      stat_q <= stat_d;
      on_q   <= on_d;
      prot_q <= prot_d;
      cnt_q  <= cnt_d;
      irq_q  <= |(stat_d & mask_d);
      trig_q <= trg_ev;
      en_q   <= on_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 7'h7f;
      oe_q  <= 7'h00;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      pin_q <= drv_w;
      oe_q  <= den_w;
      ack_q <= req_w;
      dat_q <= rd_w ? rdat_w : 32'h0;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign pin_o    = pin_q;
  assign pin_oe_o = oe_q;
  assign supply_en_o = en_q;
  assign protection_state_level_o = prot_q;
  assign trig_o = trig_q;
  assign irq_o  = irq_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_inh;
    inh_w |=> !supply_en_o ##1 !supply_en_o;
  endproperty
  a_inh: assert property (p_inh)
    else $error("inhibit did not hold supply off");

  property p_inh_lvl;
    dflt_w[PIN_INH] && !inv_q[PIN_INH] && lvl_q[PIN_INH]
      |=> !supply_en_o;
  endproperty
  a_inh_lvl: assert property (p_inh_lvl)
    else $error("high inhibit level left supply on");

  property p_clr;
    prot_q && clr_ev && !prot_trip_i |=> !prot_q;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear pulse did not clear protection");

  property p_ps;
    mode_of(mode_q, PIN_PROT) == MODE_DEFAULT && $stable(mode_q)
      |=> pin_o[PIN_PROT] == (!prot_q ^ $past(inv_q[PIN_PROT]));
  endproperty
  a_ps: assert property (p_ps)
    else $error("protection pin level wrong");

  property p_son;
    son_ev && !soff_ev && !inh_w && !prot_d |=> supply_en_o;
  endproperty
  a_son: assert property (p_son)
    else $error("sync on pulse ignored");

  property p_soff;
    soff_ev |=> !supply_en_o;
  endproperty
  a_soff: assert property (p_soff)
    else $error("sync off pulse ignored");

  property p_once;
    fall_w[PIN_TRIG] && $stable(inv_q) |=> !fall_w[PIN_TRIG];
  endproperty
  a_once: assert property (p_once)
    else $error("edge seen twice");

  property p_fall;
    $rose(trig_o) |-> $past(ef_q[PIN_TRIG]) &&
                      !ef_q[PIN_TRIG];
  endproperty
  a_fall: assert property (p_fall)
    else $error("trigger not from high-to-low edge");

  property p_stat;
    mode_of(mode_q, 0) == MODE_STATIC && $stable(oval_q) &&
    $stable(inv_q) && $stable(mode_q)
      |=> pin_o[0] == (!$past(oval_q[0]) ^ $past(inv_q[0])) && pin_oe_o[0];
  endproperty
  a_stat: assert property (p_stat)
    else $error("static level wrong");

  property p_pwm;
    mode_of(mode_q, 0) == MODE_PWM && cnt_q < low_q && !inv_q[0]
      && $stable(mode_q) && $stable(inv_q) |=> !pin_o[0];
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("waveform not low during low share");

  property p_inp;
    mode_of(mode_q, 0) == MODE_INPUT && $stable(mode_q) |=> !pin_oe_o[0];
  endproperty
  a_inp: assert property (p_inp)
    else $error("input pin driven");

  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack held beyond one cycle");

endmodule : instrument_digital_io_port

// file: dio_port_pkg.sv
// Constants and types for the instrument digital I/O port
package dio_port_pkg;
  localparam int NPIN = 7;
  localparam int CLK_HZ = 20_000_000;
  // Pin positions of the default functions
  localparam int PIN_CLR = 0;
  localparam int PIN_PROT = 1;
  localparam int PIN_OFFST = 2;
  localparam int PIN_TRIG = 3;
  localparam int PIN_INH = 4;
  localparam int PIN_SON = 5;
  localparam int PIN_SOFF = 6;
  // Register byte offsets
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_INV = 8'h04;
  localparam logic [7:0] ADR_OVAL = 8'h08;
  localparam logic [7:0] ADR_PPER = 8'h0c;
  localparam logic [7:0] ADR_PLOW = 8'h10;
  localparam logic [7:0] ADR_PIN = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h18;
  localparam logic [7:0] ADR_MASK = 8'h1c;
  localparam logic [7:0] ADR_SUP = 8'h20;
  // Supply register fields
  localparam int SUP_ON = 0;
  localparam int SUP_PROT = 1;
  localparam int SUP_EN = 2;
  // Reset values
  localparam logic [13:0] MODE_RST = 14'h0000;
  localparam logic [6:0] INV_RST = 7'h00;
  localparam logic [6:0] OVAL_RST = 7'h00;
  // Edge detector starts at each pin's idle level: pulse pins idle high,
  // the inhibit input idles low, so no false edge follows reset
  localparam logic [6:0] LVL_RST = 7'h6f;
  // Waveform defaults: 100 Hz, 10 percent low share
  localparam int PWM_FREQ_HZ = 100;
  localparam int PWM_DUTY_PCT = 10;
  localparam int PWM_PER_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int PWM_LOW_CYC = PWM_PER_CYC * PWM_DUTY_PCT / 100;

  typedef enum logic [1:0] {
    MODE_DEFAULT = 2'h0,
    MODE_INPUT   = 2'h1,
    MODE_STATIC  = 2'h2,
    MODE_PWM     = 2'h3
  } pin_mode_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_type;
endpackage : dio_port_pkg

// file: dio_partner.sv
// External equipment model that drives and samples the port pins
`timescale 1ns/1ps
module dio_partner
  import dio_port_pkg::*;
(
  // Clock and design drive
  input  wire logic            clk_i,
  input  wire logic [NPIN-1:0] drv_i,
  input  wire logic [NPIN-1:0] oe_i,
  // Resolved pin levels
  output logic      [NPIN-1:0] line_o
);
  // Idle high; the inhibit input idles low so the supply may run
  logic [NPIN-1:0] ext_q = 7'h6f;
  // Design drive wins wherever its enable is up
  assign line_o = (oe_i & drv_i) | (~oe_i & ext_q);
  task automatic pulse(input int k);
    ext_q[k] <= 1'b0;
    repeat (5) @(posedge clk_i);
    ext_q[k] <= 1'b1;
    repeat (5) @(posedge clk_i);
  endtask : pulse
endmodule : dio_partner

// file: tb_instrument_digital_io_port.sv
// Self-checking bench for the digital I/O port
`timescale 1ns/1ps
module tb_instrument_digital_io_port;
  import dio_port_pkg::*;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            prot_trip_i = 1'b0;
  wb_req_type      wb_i = '0;
  logic [31:0]     wb_dat_o;
  logic [31:0]     rd;
  logic            wb_ack_o;
  logic            supply_en_o;
  logic            protection_state_level_o;
  logic            trig_o;
  logic            irq_o;
  logic [NPIN-1:0] pin_i;
  logic [NPIN-1:0] pin_o;
  logic [NPIN-1:0] pin_oe_o;
  logic [NPIN-1:0] r;
  logic [NPIN-1:0] v;
  logic [NPIN-1:0] e;
  int              fails = 0;
  int              checks_done = 0;
  int              trig_n = 0;
  int              low_n;
  int              exp_on = 0;

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (trig_o === 1'b1) trig_n++;

  instrument_digital_io_port uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .prot_trip_i(prot_trip_i),
    .supply_en_o(supply_en_o),
    .protection_state_level_o(protection_state_level_o),
    .trig_o(trig_o), .irq_o(irq_o));
  dio_partner prt (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o),
    .line_o(pin_i));

  task automatic stop_test();
    $display("fails %0d checks_done %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : chk

  // One classic cycle; the bound cuts a missing ack short
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_i <= '0;
    if (wb_ack_o !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask : wb

  // Covers the synchroniser and edge detect delay
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask : settle

  initial begin
    void'($urandom(32'h48d6e997));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(pin_oe_o, 7'h06);
    chk(pin_o[PIN_PROT], 1'b1);
    chk(supply_en_o, exp_on);
    wb(1'b0, ADR_PPER, 0);
    chk(rd, PWM_PER_CYC);
    wb(1'b0, ADR_PLOW, 0);
    chk(rd, PWM_LOW_CYC);
    wb(1'b0, 8'h40, 0);
    chk(rd, 0);
    wb(1'b1, ADR_MASK, 32'h7f);
    prt.pulse(PIN_SON);
    settle();
    exp_on = 1;
    chk(supply_en_o, exp_on);
    chk(irq_o, 1'b1);
    prt.pulse(PIN_TRIG);
    settle();
    chk(trig_n, 1);
    wb(1'b0, ADR_STAT, 0);
    chk(rd, 32'h28);
    wb(1'b0, ADR_STAT, 0);
    chk(rd, 0);
    settle();
    chk(irq_o, 1'b0);
    // Inhibit beats any on request
    prt.ext_q[PIN_INH] <= 1'b1;
    settle();
    exp_on = 0;
    chk(supply_en_o, exp_on);
    prt.pulse(PIN_SON);
    settle();
    chk(supply_en_o, exp_on);
    prt.ext_q[PIN_INH] <= 1'b0;
    wb(1'b1, ADR_INV, 32'h10);
    prt.pulse(PIN_SON);
    settle();
    chk(supply_en_o, exp_on);
    wb(1'b1, ADR_INV, 0);
    prt.pulse(PIN_SON);
    settle();
    chk(supply_en_o, 1'b1);
    prt.pulse(PIN_SOFF);
    settle();
    chk(supply_en_o, 1'b0);
    // Protection trip, indicator polarity, clear pulse
    prt.pulse(PIN_SON);
    prot_trip_i <= 1'b1;
    @(posedge clk_i);
    prot_trip_i <= 1'b0;
    settle();
    chk(protection_state_level_o, 1'b1);
    chk(pin_o[PIN_PROT], 1'b0);
    chk(supply_en_o, 1'b0);
    wb(1'b1, ADR_INV, 32'h02);
    settle();
    chk(pin_o[PIN_PROT], 1'b1);
    prt.pulse(PIN_CLR);
    settle();
    chk(protection_state_level_o, 1'b0);
    chk(pin_o[PIN_PROT], 1'b0);
    // Register switching of the supply and its state pin
    wb(1'b1, ADR_SUP, 32'h1);
    exp_on = 1;
    chk(supply_en_o, exp_on);
    chk(pin_o[PIN_OFFST], 1'b1);
    wb(1'b0, ADR_SUP, 0);
    chk(rd, 32'h5);
    wb(1'b1, ADR_SUP, 0);
    exp_on = 0;
    chk(supply_en_o, exp_on);
    // Static outputs with random levels and polarity
    r = 7'($urandom);
    v = 7'($urandom);
    wb(1'b1, ADR_MODE, 32'h2aaa);
    wb(1'b1, ADR_OVAL, r);
    wb(1'b1, ADR_INV, v);
    settle();
    chk(pin_oe_o, 7'h7f);
    e = ~r ^ v;
    chk(pin_o, e);
    // General inputs
    wb(1'b1, ADR_MODE, 32'h1555);
    prt.ext_q <= r;
    settle();
    wb(1'b0, ADR_PIN, 0);
    chk(rd, r ^ v);
    chk(pin_oe_o, 7'h00);
    // Short waveform: period 10, low share 2
    wb(1'b1, ADR_INV, 0);
    wb(1'b1, ADR_PPER, 10);
    wb(1'b1, ADR_PLOW, 2);
    wb(1'b1, ADR_MODE, 3);
    settle();
    low_n = 0;
    repeat (20) begin
      @(posedge clk_i);
      if (pin_o[PIN_CLR] === 1'b0) low_n++;
    end
    chk(low_n, 4);
    stop_test();
  end
endmodule : tb_instrument_digital_io_port
